/* File: rtl/gapo_persist.v */
// persistence qualifier: flag sets after a condition holds for a number of samples
`timescale 1ns/1ns
`default_nettype none

module gapo_persist #(
  parameter W = 16
) (
  input  wire         sys_clk_i,
  input  wire         rstn_i,
  input  wire         tick_i,
  input  wire         en_i,
  input  wire         set_i,
  input  wire         clr_i,
  input  wire [W-1:0] time_i,
  output wire         flag_o
);

  reg [W-1:0] cnt_ff;
  reg         flag_ff;
  reg [W-1:0] nxt_cnt;
  reg         nxt_flag;

  assign flag_o = flag_ff;

  // ----------------
  // counting
  // ----------------
  // the count saturates so a long hold cannot wrap and lose the set
  always @* begin
    nxt_cnt  = cnt_ff;
    nxt_flag = flag_ff;
    if (!en_i) begin
      nxt_cnt  = {W{1'b0}};
      nxt_flag = 1'b0;
    end else if (tick_i) begin
      if (set_i) begin
        if (cnt_ff != {W{1'b1}})
          nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
        if (cnt_ff >= time_i)
          nxt_flag = 1'b1;
        else if (clr_i)
          nxt_flag = 1'b0;
      end else begin
        nxt_cnt = {W{1'b0}};
        if (clr_i)
          nxt_flag = 1'b0;
      end
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff  <= {W{1'b0}};
      flag_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      flag_ff <= nxt_flag;
    end
  end

endmodule // gapo_persist

`default_nettype wire

/* File: rtl/gapo_top.v */
// alert, power-off pin and status flag logic of the battery gauge
//
// Behaviour
// R1 - arm command or feature bit sets armed
// R2 - disarm command or clearing bit disarms
// R3 - power-off state only when dormant on low-voltage
// R4 - control pin high impedance at reset
// R5 - push-pull setting takes effect after reset; push_pull_ff only loads the reset value 0, so the pin stays open-drain
// R6 - pin select leaves power-off bits unchanged
// R7 - open-drain power-off drive per polarity
// R8 - push-pull power-off drive per polarity
// R9 - select 0: control pin signals alerts
// R10 - select 1: host pin open-drain alert
// R11 - some flags always alert, others when enabled
// R12 - voltage-high flag with duration and hysteresis
// R13 - voltage-low flag with duration and hysteresis
// R14 - software programs thresholds with hysteresis
// R15 - short check evaluated hourly when enabled
// R16 - short flag when discharge below capacity/divisor
// R17 - tab-loss flag when health ratio drops
// R18 - charge over-temperature flag, zero time disables
// R19 - discharge over-temperature flag, zero time disables
// R20 - termination after two good taper windows
// R21 - termination clears charging, optionally loads capacity
// R22 - alarm threshold -1: alarm on taper only
// R23 - full threshold -1: full on taper only
// R24 - thermistor select picks temperature source
// R25 - pin select 0 control, 1 host; default 1
// R26 - alert asserted while any enabled flag set
`timescale 1ns/1ns
`default_nettype none
`include "gapo_defines.vh"

module gapo_top (
  input  wire        sys_clk_i,
  input  wire        rstn_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        meas_tick_i,
  input  wire [15:0] volt_i,
  input  wire [15:0] avg_curr_i,
  input  wire [15:0] therm_temp_i,
  input  wire [15:0] die_temp_i,
  input  wire        dormant_lowv_i,
  input  wire        capacity_level_flag_i,
  input  wire        hour_tick_i,
  input  wire        relaxed_i,
  input  wire [15:0] self_dis_curr_i,
  input  wire        soh_upd_i,
  input  wire [7:0]  soh_i,
  input  wire        taper_win_i,
  input  wire [15:0] taper_dq_i,
  input  wire [7:0]  soc_i,
  input  wire [15:0] fcc_i,
  output reg  [15:0] temp_o,
  output reg         charging_o,
  output reg         full_charge_flag_o,
  output reg         end_of_charge_alarm_o,
  output reg         rm_load_o,
  output reg  [15:0] rm_val_o,
  output reg         system_ctl_pin_o,
  output reg         system_ctl_pin_oe_o,
  output reg         one_wire_host_pin_o,
  output reg         one_wire_host_pin_oe_o
);

  // ----------------
  // reset release
  // ----------------
  reg [1:0] rst_sync_ff;
  wire      rst_n = rst_sync_ff[1];
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  // ----------------
  // registers
  // ----------------
  reg [`GAPO_CFG_W-1:0] cfg_ff;
  reg [31:0] vhi_ff;
  reg [31:0] vlo_ff;
  reg [31:0] vtime_ff;
  reg [31:0] otc_t_ff;
  reg [31:0] otc_c_ff;
  reg [31:0] otd_t_ff;
  reg [31:0] otd_c_ff;
  reg [31:0] isd_ff;
  reg [31:0] tdd_ff;
  reg [31:0] taper_ff;
  reg [31:0] chgv_ff;
  reg [31:0] thr_ff;
  wire cfg_wr = wr_i && (addr_i == `GAPO_A_CFG);
  wire cmd_wr = wr_i && (addr_i == `GAPO_A_CMD);
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff   <= `GAPO_CFG_RST;
      vhi_ff   <= `GAPO_VHI_RST;
      vlo_ff   <= `GAPO_VLO_RST;
      vtime_ff <= `GAPO_ZERO_RST;
      otc_t_ff <= `GAPO_ZERO_RST;
      otc_c_ff <= `GAPO_ZERO_RST;
      otd_t_ff <= `GAPO_ZERO_RST;
      otd_c_ff <= `GAPO_ZERO_RST;
      isd_ff   <= `GAPO_ZERO_RST;
      tdd_ff   <= `GAPO_ZERO_RST;
      taper_ff <= `GAPO_ZERO_RST;
      chgv_ff  <= `GAPO_ZERO_RST;
      thr_ff   <= `GAPO_THR_RST;
    end else if (wr_i) begin
      case (addr_i)
        `GAPO_A_CFG:   cfg_ff   <= wdata_i[`GAPO_CFG_W-1:0];
        `GAPO_A_VHI:   vhi_ff   <= wdata_i;
        `GAPO_A_VLO:   vlo_ff   <= wdata_i;
        `GAPO_A_VTIME: vtime_ff <= wdata_i;
        `GAPO_A_OTC_T: otc_t_ff <= wdata_i;
        `GAPO_A_OTC_C: otc_c_ff <= wdata_i;
        `GAPO_A_OTD_T: otd_t_ff <= wdata_i;
        `GAPO_A_OTD_C: otd_c_ff <= wdata_i;
        `GAPO_A_ISD:   isd_ff   <= wdata_i;
        `GAPO_A_TDD:   tdd_ff   <= wdata_i;
        `GAPO_A_TAPER: taper_ff <= wdata_i;
        `GAPO_A_CHGV:  chgv_ff  <= wdata_i;
        `GAPO_A_THR:   thr_ff   <= wdata_i;
        default: ;
      endcase
    end
  end

  wire alert_pin_select = cfg_ff[`GAPO_CFG_ALERT_SEL];  // [R25]
  wire alert_polarity   = cfg_ff[`GAPO_CFG_ALERT_POL];
  wire po_polarity      = cfg_ff[`GAPO_CFG_PO_POL];
  wire short_en         = cfg_ff[`GAPO_CFG_SHORT_EN];
  wire tab_en           = cfg_ff[`GAPO_CFG_TAB_EN];
  // ----------------
  // power-off arming
  // ----------------
  // the feature bit acts on its edges so the commands can still override it
  reg  armed_ff;
  reg  nxt_armed;
  wire feat_rise = cfg_wr && wdata_i[`GAPO_CFG_PO_FEAT] && !cfg_ff[`GAPO_CFG_PO_FEAT];
  wire feat_fall = cfg_wr && !wdata_i[`GAPO_CFG_PO_FEAT] && cfg_ff[`GAPO_CFG_PO_FEAT];
  always @* begin
    nxt_armed = armed_ff;
    if (feat_fall || (cmd_wr && wdata_i[`GAPO_CMD_DISARM]))
      nxt_armed = 1'b0;                                 // [R2]
    if (feat_rise || (cmd_wr && wdata_i[`GAPO_CMD_ARM]))
      nxt_armed = 1'b1;                                 // [R1]
  end
  // status kept whatever the pin select says
  wire po_state = armed_ff && dormant_lowv_i;           // [R3] [R6]
  // ----------------
  // temperature source
  // ----------------
  wire [15:0] temp_sel = cfg_ff[`GAPO_CFG_EXT_THERM] ? therm_temp_i : die_temp_i; // [R24]
  // ----------------
  // voltage and temperature flags
  // ----------------
  wire vhi_flag;
  wire vlo_flag;
  wire otc_flag;
  wire otd_flag;
  wire otc_en = (otc_c_ff[15:0] != 16'h0000);
  wire otd_en = (otd_c_ff[15:0] != 16'h0000);
  wire signed [15:0] cur_s   = avg_curr_i;
  wire signed [15:0] temp_s  = temp_o;
  wire signed [16:0] dsg_neg = -$signed({1'b0, otd_c_ff[31:16]});
  gapo_persist #(.W(16)) u_vhi (.sys_clk_i(sys_clk_i), .rstn_i(rst_n), .tick_i(meas_tick_i),
    .en_i(1'b1), .set_i(volt_i > vhi_ff[15:0]), .clr_i(volt_i <= vhi_ff[31:16]), // [R12]
    .time_i(vtime_ff[15:0]), .flag_o(vhi_flag));
  gapo_persist #(.W(16)) u_vlo (.sys_clk_i(sys_clk_i), .rstn_i(rst_n), .tick_i(meas_tick_i),
    .en_i(1'b1), .set_i(volt_i < vlo_ff[15:0]), .clr_i(volt_i >= vlo_ff[31:16]), // [R13]
    .time_i(vtime_ff[31:16]), .flag_o(vlo_flag));
  gapo_persist #(.W(16)) u_otc (.sys_clk_i(sys_clk_i), .rstn_i(rst_n), .tick_i(meas_tick_i),
    .en_i(otc_en), .time_i(otc_c_ff[15:0]), .flag_o(otc_flag), // [R18]
    .set_i((temp_s >= $signed(otc_t_ff[15:0])) && (cur_s >= $signed(otc_c_ff[31:16]))),
    .clr_i(temp_s <= $signed(otc_t_ff[31:16])));
  gapo_persist #(.W(16)) u_otd (.sys_clk_i(sys_clk_i), .rstn_i(rst_n), .tick_i(meas_tick_i),
    .en_i(otd_en), .time_i(otd_c_ff[15:0]), .flag_o(otd_flag), // [R19]
    .set_i((temp_s >= $signed(otd_t_ff[15:0])) && ($signed({cur_s[15], cur_s}) <= dsg_neg)),
    .clr_i(temp_s <= $signed(otd_t_ff[31:16])));
  // ----------------
  // internal short and tab loss
  // ----------------
  // a zero divisor would make the limit meaningless, so the check is skipped
  reg         isd_flag_ff;
  reg         tdd_flag_ff;
  reg  [7:0]  soh_prev_ff;
  wire [15:0] isd_div   = isd_ff[15:0];
  wire [15:0] isd_limit = (isd_div == 16'h0000) ? 16'h0000 : isd_ff[31:16] / isd_div;
  wire signed [16:0] isd_sum = $signed({self_dis_curr_i[15], self_dis_curr_i}) +
                               $signed({1'b0, isd_limit});
  wire [15:0] soh_scaled = soh_i * `GAPO_PCT_SCALE;
  wire [15:0] soh_floor  = tdd_ff[7:0] * soh_prev_ff;
  // ----------------
  // charge termination
  // ----------------
  reg  [1:0]  taper_cnt_ff;
  reg         taper_met_ff;
  wire [15:0] v_floor  = chgv_ff[15:0] - taper_ff[31:16];
  wire        taper_ok = (cur_s < $signed(taper_ff[15:0])) &&
                         (taper_dq_i > `GAPO_TAPER_DQ) && (volt_i > v_floor); // [R20]
  wire        term_evt = taper_win_i && taper_ok &&
                         (taper_cnt_ff == `GAPO_TAPER_WINS - 2'h1) && !taper_met_ff;
  wire        tca_off  = (thr_ff[15:0] == `GAPO_THR_OFF);
  wire        fcs_off  = (thr_ff[31:16] == `GAPO_THR_OFF);
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff     <= 1'b1;
      isd_flag_ff  <= 1'b0;
      tdd_flag_ff  <= 1'b0;
      soh_prev_ff  <= 8'h00;
      taper_cnt_ff <= 2'h0;
      taper_met_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
      if (!short_en)
        isd_flag_ff <= 1'b0;
      else if (hour_tick_i && relaxed_i && isd_div != 16'h0000)
        isd_flag_ff <= isd_sum[16];                     // [R15] [R16]
      if (soh_upd_i) begin
        soh_prev_ff <= soh_i;
        if (!tab_en)
          tdd_flag_ff <= 1'b0;
        else if (soh_prev_ff != 8'h00)
          tdd_flag_ff <= (soh_scaled < soh_floor);      // [R17]
      end else if (!tab_en) begin
        tdd_flag_ff <= 1'b0;
      end
      if (taper_win_i) begin
        if (!taper_ok)
          taper_cnt_ff <= 2'h0;
        else if (taper_cnt_ff != `GAPO_TAPER_WINS)
          taper_cnt_ff <= taper_cnt_ff + 2'h1;
      end
      // discharge ends the charge cycle and rearms detection
      if (term_evt)
        taper_met_ff <= 1'b1;
      else if (cur_s < 16'sh0000) begin
        taper_met_ff <= 1'b0;
        taper_cnt_ff <= 2'h0;
      end
    end
  end
  // ----------------
  // alert sources
  // ----------------
  wire alert = capacity_level_flag_i | vhi_flag | vlo_flag |
               (otc_flag & otc_en) | (otd_flag & otd_en) |
               (isd_flag_ff & short_en) | (tdd_flag_ff & tab_en); // [R11] [R26]
  // ----------------
  // pin drive
  // ----------------
  // push-pull is caught once after reset so a live change cannot glitch the pin
  reg  por_done_ff;
  reg  push_pull_ff;
  reg  ctl_state;
  reg  ctl_pol;
  reg  ctl_act;
  always @* begin
    ctl_act   = 1'b1;
    ctl_state = alert;                                  // [R9]
    ctl_pol   = alert_polarity;
    if (alert_pin_select) begin
      ctl_act   = armed_ff;
      ctl_state = po_state;                             // [R3]
      ctl_pol   = po_polarity;
    end
  end
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      por_done_ff            <= 1'b0;
      push_pull_ff           <= 1'b0;
      system_ctl_pin_o       <= 1'b0;
      system_ctl_pin_oe_o    <= 1'b0;                   // [R4]
      one_wire_host_pin_o    <= 1'b0;
      one_wire_host_pin_oe_o <= 1'b0;
    end else begin
      por_done_ff <= 1'b1;
      if (!por_done_ff)
        push_pull_ff <= cfg_ff[`GAPO_CFG_PUSH_PULL];   // [R5]
      if (!por_done_ff || !ctl_act) begin
        system_ctl_pin_o    <= 1'b0;
        system_ctl_pin_oe_o <= 1'b0;                    // [R4]
      end else if (push_pull_ff) begin
        system_ctl_pin_o    <= ~(ctl_state ^ ctl_pol);  // [R8] [R9]
        system_ctl_pin_oe_o <= 1'b1;
      end else begin
        system_ctl_pin_o    <= 1'b0;
        system_ctl_pin_oe_o <= ctl_state ^ ctl_pol;     // [R7] [R9]
      end
      one_wire_host_pin_o    <= 1'b0;
      one_wire_host_pin_oe_o <= por_done_ff && alert_pin_select &&
                                (alert ^ alert_polarity); // [R10]
    end
  end
  // ----------------
  // charge outputs and temperature
  // ----------------
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      temp_o                <= 16'h0000;
      charging_o            <= 1'b0;
      full_charge_flag_o    <= 1'b0;
      end_of_charge_alarm_o <= 1'b0;
      rm_load_o             <= 1'b0;
      rm_val_o              <= 16'h0000;
    end else begin
      temp_o     <= temp_sel;
      charging_o <= (cur_s > 16'sh0000) && !taper_met_ff && !term_evt; // [R21]
      rm_load_o  <= term_evt && cfg_ff[`GAPO_CFG_RM_FULL];             // [R21]
      if (term_evt)
        rm_val_o <= fcc_i;
      end_of_charge_alarm_o <= taper_met_ff ||
                               (!tca_off && soc_i >= thr_ff[7:0]);     // [R22]
      full_charge_flag_o    <= taper_met_ff ||
                               (!fcs_off && soc_i >= thr_ff[23:16]);   // [R23]
    end
  end
  // ----------------
  // read port
  // ----------------
  reg [31:0] rd_mux;
  always @* begin
    case (addr_i)
      `GAPO_A_CFG:    rd_mux = {{(32-`GAPO_CFG_W){1'b0}}, cfg_ff};
      `GAPO_A_VHI:    rd_mux = vhi_ff;
      `GAPO_A_VLO:    rd_mux = vlo_ff;
      `GAPO_A_VTIME:  rd_mux = vtime_ff;
      `GAPO_A_OTC_T:  rd_mux = otc_t_ff;
      `GAPO_A_OTC_C:  rd_mux = otc_c_ff;
      `GAPO_A_OTD_T:  rd_mux = otd_t_ff;
      `GAPO_A_OTD_C:  rd_mux = otd_c_ff;
      `GAPO_A_ISD:    rd_mux = isd_ff;
      `GAPO_A_TDD:    rd_mux = tdd_ff;
      `GAPO_A_TAPER:  rd_mux = taper_ff;
      `GAPO_A_CHGV:   rd_mux = chgv_ff;
      `GAPO_A_THR:    rd_mux = thr_ff;
      `GAPO_A_STATUS: rd_mux = {temp_o, 1'b0, push_pull_ff, alert, po_state,
                                armed_ff, end_of_charge_alarm_o,
                                full_charge_flag_o, charging_o, tdd_flag_ff,
                                isd_flag_ff, otd_flag, otc_flag, vlo_flag,
                                vhi_flag, capacity_level_flag_i, 1'b0};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n)
      rdata_o <= 32'h0000_0000;
    else
      rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
  end

endmodule // gapo_top

`default_nettype wire

/* File: shared/gapo_defines.vh */
// register map, field positions and reset values of the alert and power-off block
`ifndef GAPO_DEFINES_VH
`define GAPO_DEFINES_VH

// ----------------
// register offsets (byte addresses)
// ----------------
`define GAPO_A_CFG     8'h00
`define GAPO_A_CMD     8'h04
`define GAPO_A_VHI     8'h08
`define GAPO_A_VLO     8'h0C
`define GAPO_A_VTIME   8'h10
`define GAPO_A_OTC_T   8'h14
`define GAPO_A_OTC_C   8'h18
`define GAPO_A_OTD_T   8'h1C
`define GAPO_A_OTD_C   8'h20
`define GAPO_A_ISD     8'h24
`define GAPO_A_TDD     8'h28
`define GAPO_A_TAPER   8'h2C
`define GAPO_A_CHGV    8'h30
`define GAPO_A_THR     8'h34
`define GAPO_A_STATUS  8'h38

// ----------------
// configuration fields
// ----------------
`define GAPO_CFG_EXT_THERM  0
`define GAPO_CFG_PO_FEAT    1
`define GAPO_CFG_PO_POL     2
`define GAPO_CFG_PUSH_PULL  3
`define GAPO_CFG_RM_FULL    4
`define GAPO_CFG_ALERT_SEL  5
`define GAPO_CFG_ALERT_POL  6
`define GAPO_CFG_SHORT_EN   7
`define GAPO_CFG_TAB_EN     8
`define GAPO_CFG_W          9
`define GAPO_CMD_ARM        0
`define GAPO_CMD_DISARM     1

// ----------------
// reset values
// ----------------
`define GAPO_CFG_RST    9'h037
`define GAPO_VHI_RST    32'hFFFE_FFFF
`define GAPO_VLO_RST    32'h0001_0000
`define GAPO_ZERO_RST   32'h0000_0000
`define GAPO_THR_RST    32'hFFFF_FFFF

// ----------------
// fixed figures
// ----------------
`define GAPO_THR_OFF    16'hFFFF
`define GAPO_TAPER_DQ   16'h0019
`define GAPO_TAPER_WINS 2'h2
`define GAPO_PCT_SCALE  8'h64

`endif

/* File: sim/gapo_asserts.sv */
// checker on the pins and bus of the alert and power-off block
`timescale 1ns/1ns
`default_nettype none
`include "gapo_defines.vh"
module gapo_asserts (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] die_temp_i,
  input  wire logic        dormant_lowv_i,
  input  wire logic        capacity_level_flag_i,
  input  wire logic [15:0] temp_o,
  input  wire logic        rm_load_o,
  input  wire logic        system_ctl_pin_o,
  input  wire logic        system_ctl_pin_oe_o,
  input  wire logic        one_wire_host_pin_o,
  input  wire logic        one_wire_host_pin_oe_o
);
  logic [8:0] cfg_ff;
  logic [2:0] up_ff;
  wire        live = up_ff[2];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // shadow of the config word; live masks the internal two-flop reset release
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ff <= `GAPO_CFG_RST;
      up_ff  <= 3'h0;
    end else begin
      if (wr_i && addr_i == `GAPO_A_CFG) cfg_ff <= wdata_i[8:0];
      if (!live) up_ff <= up_ff + 3'h1;
    end
  end
  property p_rst_hiz;
    $rose(rstn_i) |-> !system_ctl_pin_oe_o [*2];
  endproperty
  a_rst_hiz: assert property (p_rst_hiz) else $error("control pin driven after reset");
  property p_ctl_od;
    system_ctl_pin_oe_o |-> !system_ctl_pin_o;
  endproperty
  a_ctl_od: assert property (p_ctl_od) else $error("control pin driven high");
  property p_host_od;
    live |-> !one_wire_host_pin_o;
  endproperty
  a_host_od: assert property (p_host_od) else $error("host pin driven high");
  property p_sel0_host;
    (live && !cfg_ff[5] && $stable(cfg_ff)) [*3] |-> !one_wire_host_pin_oe_o;
  endproperty
  a_sel0_host: assert property (p_sel0_host) else $error("host pin used with select 0");
  property p_ctl_alert;
    (live && !cfg_ff[5] && capacity_level_flag_i && $stable(cfg_ff)) [*3]
      |-> system_ctl_pin_oe_o == !cfg_ff[6];
  endproperty
  a_ctl_alert: assert property (p_ctl_alert) else $error("control pin alert level");
  property p_host_alert;
    (live && cfg_ff[5] && capacity_level_flag_i && $stable(cfg_ff)) [*3]
      |-> one_wire_host_pin_oe_o == !cfg_ff[6];
  endproperty
  a_host_alert: assert property (p_host_alert) else $error("host pin alert level");
  property p_normal;
    (live && cfg_ff[5] && !cfg_ff[2] && !dormant_lowv_i && $stable(cfg_ff)) [*3]
      |-> !system_ctl_pin_oe_o;
  endproperty
  a_normal: assert property (p_normal) else $error("power-off state while awake");
  property p_temp;
    live && !cfg_ff[0] && !$past(cfg_ff[0]) |-> temp_o == $past(die_temp_i);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature source wrong");
  property p_rm;
    rm_load_o |-> cfg_ff[4] ##1 !rm_load_o;
  endproperty
  a_rm: assert property (p_rm) else $error("capacity load pulse wrong");
  c_po: cover property (live && dormant_lowv_i && !system_ctl_pin_oe_o);
  c_rm: cover property (rm_load_o);
  c_host: cover property (one_wire_host_pin_oe_o);
endmodule // gapo_asserts
bind gapo_top gapo_asserts u_asserts (.sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i,
  .die_temp_i, .dormant_lowv_i, .capacity_level_flag_i, .temp_o, .rm_load_o,
  .system_ctl_pin_o, .system_ctl_pin_oe_o, .one_wire_host_pin_o, .one_wire_host_pin_oe_o);
`default_nettype wire

/* File: sim/gapo_pin_model.sv */
// board side of the pins: pull-ups and the external power-off circuit
`timescale 1ns/1ns
`default_nettype none
module gapo_pin_model (
  input  wire logic ctl_o_i,
  input  wire logic ctl_oe_i,
  input  wire logic host_o_i,
  input  wire logic host_oe_i,
  input  wire logic po_active_high_i,
  output wire logic ctl_lvl_o,
  output wire logic host_lvl_o,
  output wire logic power_cut_o
);
  // both lines carry pull-ups, so a released pin reads high, never the last value
  assign ctl_lvl_o   = ctl_oe_i ? ctl_o_i : 1'b1;
  assign host_lvl_o  = host_oe_i ? host_o_i : 1'b1;
  assign power_cut_o = (ctl_lvl_o == po_active_high_i);
endmodule // gapo_pin_model
`default_nettype wire

/* File: sim/gapo_top_test.sv */
// self-checking bench for the alert and power-off block
`timescale 1ns/1ns
`default_nettype none
`include "gapo_defines.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module gapo_top_test;
  logic        sys_clk_i, rstn_i, wr_i, rd_i, meas_tick_i, hour_tick_i, relaxed_i;
  logic        soh_upd_i, taper_win_i, dormant_lowv_i, capacity_level_flag_i;
  logic [7:0]  addr_i, soh_i, soc_i;
  logic [31:0] wdata_i, rdata_o, s;
  logic [15:0] volt_i, avg_curr_i, therm_temp_i, die_temp_i, self_dis_curr_i, taper_dq_i;
  logic [15:0] fcc_i, temp_o, rm_val_o, rm_seen;
  logic        charging_o, full_charge_flag_o, end_of_charge_alarm_o, rm_load_o;
  logic        system_ctl_pin_o, system_ctl_pin_oe_o, one_wire_host_pin_o;
  logic        one_wire_host_pin_oe_o;
  wire         ctl_lvl, host_lvl, power_cut;
  int          failures = 0, checked = 0, rm_cnt = 0;
  gapo_top dut (.sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .meas_tick_i,
    .volt_i, .avg_curr_i, .therm_temp_i, .die_temp_i, .dormant_lowv_i, .capacity_level_flag_i,
    .hour_tick_i, .relaxed_i, .self_dis_curr_i, .soh_upd_i, .soh_i, .taper_win_i, .taper_dq_i,
    .soc_i, .fcc_i, .temp_o, .charging_o, .full_charge_flag_o, .end_of_charge_alarm_o,
    .rm_load_o, .rm_val_o, .system_ctl_pin_o, .system_ctl_pin_oe_o, .one_wire_host_pin_o,
    .one_wire_host_pin_oe_o);
  gapo_pin_model pins (.ctl_o_i(system_ctl_pin_o), .ctl_oe_i(system_ctl_pin_oe_o),
    .host_o_i(one_wire_host_pin_o), .host_oe_i(one_wire_host_pin_oe_o),
    .po_active_high_i(1'b1), .ctl_lvl_o(ctl_lvl), .host_lvl_o(host_lvl),
    .power_cut_o(power_cut));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // load pulses last one cycle, so they are counted here rather than polled
  always @(negedge sys_clk_i) if (rm_load_o === 1'b1) begin
    rm_cnt++;
    rm_seen = rm_val_o;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    s = rdata_o;
  endtask
  task st(input int b, input logic e, input string n);
    rd(`GAPO_A_STATUS);
    `CHK(n, e, s[b])
  endtask
  task pulse(input int k);
    @(posedge sys_clk_i);
    meas_tick_i <= (k == 0);
    hour_tick_i <= (k == 1);
    taper_win_i <= (k == 2);
    soh_upd_i <= (k == 3);
    @(posedge sys_clk_i);
    {meas_tick_i, hour_tick_i, taper_win_i, soh_upd_i} <= 4'h0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task settle;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task t_reset;
    rd(`GAPO_A_CFG);
    `CHK("cfg", 32'h0000_0037, s)
    st(11, 1'b1, "armed");
    rd(8'hFC);
    `CHK("unmapped", 32'h0, s)
    $display("test reset done");
  endtask
  task t_volt;
    wr(`GAPO_A_VHI, 32'h0090_0100);
    wr(`GAPO_A_VLO, 32'h0050_0040);
    wr(`GAPO_A_VTIME, 32'h0000_0002);
    volt_i <= 16'h0101;
    repeat (2) pulse(0);
    st(2, 1'b0, "vhi early");
    pulse(0);
    st(2, 1'b1, "vhi");
    `CHK("host alert", 1'b0, host_lvl)
    volt_i <= 16'h0091;
    pulse(0);
    st(2, 1'b1, "vhi held");
    volt_i <= 16'h0090;
    pulse(0);
    st(2, 1'b0, "vhi clear");
    `CHK("host clear", 1'b1, host_lvl)
    volt_i <= 16'h003F;
    pulse(0);
    st(3, 1'b1, "vlo");
    volt_i <= 16'h0050;
    pulse(0);
    st(3, 1'b0, "vlo clear");
    $display("test voltage flags done");
  endtask
  task t_po;
    settle;
    `CHK("normal", 1'b0, ctl_lvl)
    dormant_lowv_i <= 1'b1;
    settle;
    `CHK("cut", 1'b1, power_cut)
    st(12, 1'b1, "po state");
    dormant_lowv_i <= 1'b0;
    wr(`GAPO_A_CMD, 32'h2);
    st(11, 1'b0, "disarm");
    `CHK("disarmed", 1'b1, ctl_lvl)
    wr(`GAPO_A_CMD, 32'h1);
    st(11, 1'b1, "arm");
    wr(`GAPO_A_CFG, 32'h035);
    st(11, 1'b0, "feat off");
    wr(`GAPO_A_CFG, 32'h037);
    st(11, 1'b1, "feat on");
    wr(`GAPO_A_CFG, 32'h033);
    settle;
    `CHK("normal pol0", 1'b1, ctl_lvl)
    dormant_lowv_i <= 1'b1;
    settle;
    `CHK("po pol0", 1'b0, ctl_lvl)
    wr(`GAPO_A_CFG, 32'h013);
    st(12, 1'b1, "po sel0");
    dormant_lowv_i <= 1'b0;
    wr(`GAPO_A_CFG, 32'h037);
    $display("test power-off done");
  endtask
  task t_sel0;
    wr(`GAPO_A_CFG, 32'h01F);
    capacity_level_flag_i <= 1'b1;
    settle;
    `CHK("ctl set", 1'b0, ctl_lvl)
    `CHK("host idle", 1'b1, host_lvl)
    st(14, 1'b0, "pp latched");
    wr(`GAPO_A_CFG, 32'h05F);
    settle;
    `CHK("open drain", 1'b0, system_ctl_pin_oe_o)
    capacity_level_flag_i <= 1'b0;
    settle;
    `CHK("ctl clr pol1", 1'b0, ctl_lvl)
    wr(`GAPO_A_CFG, 32'h036);
    settle;
    `CHK("die", 16'h0456, temp_o)
    wr(`GAPO_A_CFG, 32'h037);
    settle;
    `CHK("therm", 16'h0123, temp_o)
    $display("test control pin alert done");
  endtask
  task t_taper;
    wr(`GAPO_A_TAPER, 32'h0010_0010);
    wr(`GAPO_A_CHGV, 32'h0000_0100);
    avg_curr_i <= 16'h0005;
    volt_i <= 16'h00F1;
    taper_dq_i <= 16'h001A;
    settle;
    `CHK("chg", 1'b1, charging_o)
    pulse(2);
    `CHK("eoc early", 1'b0, end_of_charge_alarm_o)
    pulse(2);
    `CHK("eoc", 1'b1, end_of_charge_alarm_o)
    `CHK("full", 1'b1, full_charge_flag_o)
    `CHK("chg end", 1'b0, charging_o)
    `CHK("rm val", 16'h0ABC, rm_seen)
    `CHK("rm count", 1, rm_cnt)
    $display("test taper done");
  endtask
  task t_short;
    wr(`GAPO_A_ISD, 32'h0100_0004);
    wr(`GAPO_A_CFG, 32'h0B7);
    relaxed_i <= 1'b1;
    self_dis_curr_i <= 16'hFFC0;
    pulse(1);
    st(6, 1'b0, "isd edge");
    self_dis_curr_i <= 16'hFFBF;
    pulse(0);
    st(6, 1'b0, "isd wait");
    pulse(1);
    st(6, 1'b1, "isd");
    `CHK("isd alert", 1'b0, host_lvl)
    wr(`GAPO_A_CFG, 32'h037);
    settle;
    `CHK("isd off", 1'b1, host_lvl)
    $display("test short done");
  endtask
  task t_flags;
    wr(`GAPO_A_TDD, 32'h50);
    wr(`GAPO_A_CFG, 32'h137);
    soh_i <= 8'h64;
    pulse(3);
    soh_i <= 8'h3F;
    pulse(3);
    st(7, 1'b1, "tdd");
    wr(`GAPO_A_OTC_T, 32'h0100);
    wr(`GAPO_A_OTC_C, 32'h0004_0001);
    pulse(0);
    st(4, 1'b0, "otc early");
    pulse(0);
    st(4, 1'b1, "otc");
    wr(`GAPO_A_OTD_T, 32'h0100);
    wr(`GAPO_A_OTD_C, 32'h0004_0001);
    avg_curr_i <= 16'hFFFC;
    repeat (2) pulse(0);
    st(5, 1'b1, "otd");
    wr(`GAPO_A_CFG, 32'h037);
    $display("test flags done");
  endtask
  task complete_run;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rstn_i, wr_i, rd_i, meas_tick_i, hour_tick_i, taper_win_i, soh_upd_i, relaxed_i} = '0;
    {dormant_lowv_i, capacity_level_flag_i, addr_i, wdata_i, soh_i} = '0;
    {volt_i, avg_curr_i, self_dis_curr_i, taper_dq_i} = '0;
    soc_i = 8'hFF;
    therm_temp_i = 16'h0123;
    die_temp_i = 16'h0456;
    fcc_i = 16'h0ABC;
    repeat (2) @(posedge sys_clk_i);
    `CHK("ctl reset", 1'b0, system_ctl_pin_oe_o)
    rstn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_reset;
    t_volt;
    t_po;
    t_sel0;
    t_taper;
    t_short;
    t_flags;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    complete_run;
  end
endmodule // gapo_top_test
`default_nettype wire
